/* dv/chain_host_model.sv */
// primary-side partner: power-good source, link stop and width negotiation
`timescale 1ns/1ps
`default_nettype none
module chain_host_model
    import io_chain_pkg::*;
(
    input wire logic clk_i,
    output logic power_good_o,
    output logic link_stop_n_o,
    output logic [LINK_COUNT-1:0] neg_done_o,
    output logic [LINK_COUNT*WID_W-1:0] neg_in_o,
    output logic [LINK_COUNT*WID_W-1:0] neg_out_o
);
    // power stays bad until the host raises it
    initial
    begin
        power_good_o = 1'b0;
        link_stop_n_o = 1'b1;
        neg_done_o = 2'h0;
        neg_in_o = 6'h24;
        neg_out_o = 6'h24;
    end
    // cold start: power-good, then negotiation offers 32 bits
    task automatic power_up();
        repeat (3) @(posedge clk_i);
        power_good_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        neg_done_o <= 2'h3;
        neg_in_o <= 6'h1B;
        neg_out_o <= 6'h1B;
        @(posedge clk_i);
        // released result lines go back to the 6'h24 pattern they held before power-up
        neg_done_o <= 2'h0;
        neg_in_o <= 6'h24;
        neg_out_o <= 6'h24;
    endtask
    // one disconnect-reconnect: low one edge, then high
    task automatic reconnect();
        @(posedge clk_i);
        link_stop_n_o <= 1'b0;
        @(posedge clk_i);
        link_stop_n_o <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

/* dv/io_chain_cfg_tb.sv */
// self-checking bench for the chain device configuration logic
`timescale 1ns/1ps
`default_nettype none
module io_chain_cfg_tb
    import io_chain_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, src = 1'b0;
    logic [ADR_W-1:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, dat_o, rd;
    logic ack, err, ok, pg, stop_n, pg_sec, rst_sec, hl;
    logic [LINK_COUNT-1:0] nd;
    logic [LINK_COUNT-1:0] idone = 2'h0, lerr = 2'h0;
    logic [5:0] nin, nout, w_in, w_out;
    logic [TAG_W-1:0] base, slots;
    logic [TAG_W-1:0] next_free_tag = 5'h01; // tag zero stays with the host
    logic [31:0] tag_grouping_mask = 32'h0000_0000; // cleared
    logic partial_grouping_flag = 1'b0, no_grouping_flag = 1'b0;
    wire logic [4:0] flags;
    logic discard;
    localparam logic [WID_W-1:0] MAX_W_IN = 3'h3;
    localparam logic [WID_W-1:0] MAX_W_OUT = 3'h3;
    int n_fail = 0, total_checks = 0;
    always #2 clk_i = ~clk_i;
    chain_host_model chain_host_model_i (.clk_i(clk_i), .power_good_o(pg),
        .link_stop_n_o(stop_n), .neg_done_o(nd), .neg_in_o(nin),
        .neg_out_o(nout));
    io_chain_cfg io_chain_cfg_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .wb_err_o(err), .link_src_i(src), .power_good_i(pg),
        .link_stop_n_i(stop_n), .init_done_i(idone), .link_err_i(lerr),
        .neg_done_i(nd), .neg_in_i(nin), .neg_out_i(nout),
        .power_good_sec_o(pg_sec), .reset_sec_o(rst_sec),
        .host_link_o(hl), .default_dir_o(flags[0]),
        .bus_master_o(flags[1]), .base_tag_number_o(base),
        .discard_dead_o(discard), .chain_terminus_flag_o(flags[2]),
        .transmitter_shutdown_o(flags[3]), .tag_reorder_block_o(flags[4]),
        .width_in_o(w_in), .width_out_o(w_out));
    // ---------------------------------------------------------------
    // access and compare tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    // classic cycle; answer and read data taken on the edge that sees them
    task automatic wb(input logic w, input logic [4:0] tag,
        input logic [6:0] off, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {tag, off};
        sel <= s;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
        ok = ack;
        rd = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard, far beyond the fewer than a hundred cycles the tests take
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        print_verdict();
    end
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        chk(rst_sec, 1'b1);
        chk(pg_sec, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        chain_host_model_i.power_up();
        @(negedge clk_i);
        chk(pg_sec, 1'b1);
        chk(rst_sec, 1'b0);
        chk(discard, 1'b0);
        chk(w_in[2:0], WID_8);
        chk(w_out[2:0], WID_8);
        $display("test reset and cold start done");
        wb(1'b0, 5'h00, OFF_BASE_TAG, 4'hF, 32'h0);
        chk(ok, 1'b1);
        chk(rd, 32'h0);
        src <= 1'b1;
        wb(1'b1, 5'h00, OFF_COMMAND, 4'h1, 32'h0);
        @(negedge clk_i);
        chk(hl, 1'b1);
        wb(1'b0, 5'h00, OFF_COMMAND, 4'hF, 32'h0);
        chk(rd[CMD_HOST_LINK], 1'b1);
        $display("test default tag and host pointer done");
        wb(1'b0, 5'h00, OFF_SLOT_COUNT, 4'hF, 32'h0);
        chk(rd, 32'h1);
        slots = rd[TAG_W-1:0];
        chk(32'(next_free_tag) + rd, 32'h2); // stays within tag 31
        wb(1'b1, 5'h00, OFF_BASE_TAG, 4'h1, 32'(next_free_tag));
        next_free_tag = next_free_tag + slots;
        @(negedge clk_i);
        chk(base, 5'h01);
        // tag zero now unanswered: chain end, no slave host reached
        wb(1'b0, 5'h00, OFF_BASE_TAG, 4'hF, 32'h0);
        chk(ok, 1'b0);
        wb(1'b0, 5'h01, OFF_BASE_TAG, 4'hF, 32'h0);
        chk(ok, 1'b1);
        chk(rd, 32'h1);
        idone <= 2'h1;
        lerr <= 2'h2;
        @(posedge clk_i);
        lerr <= 2'h0;
        wb(1'b0, 5'h01, OFF_STATUS, 4'hF, 32'h0);
        chk(rd, 32'h21);
        wb(1'b1, 5'h01, OFF_STATUS, 4'h1, 32'h20);
        wb(1'b0, 5'h01, OFF_STATUS, 4'hF, 32'h0);
        chk(rd, 32'h1);
        chk(32'(next_free_tag), 32'h2);
        $display("test base tag move done");
        // partial grouping set here, so full grouping is off from this device
        partial_grouping_flag = 1'b1;
        wb(1'b1, 5'h01, OFF_LINK_CTRL, 4'h1, 32'h8);
        wb(1'b0, 5'h01, OFF_LINK_CTRL, 4'hF, 32'h0);
        chk(rd, 32'h8);
        no_grouping_flag = !rd[CTL_REORDER];
        if (!partial_grouping_flag && !no_grouping_flag)
            tag_grouping_mask = tag_grouping_mask | 32'h0000_000E;
        chk(tag_grouping_mask, 32'h0);
        wb(1'b1, 5'h01, OFF_LINK_CTRL, 4'h1, 32'hA); // terminus first
        wb(1'b1, 5'h01, OFF_LINK_CTRL, 4'h1, 32'hF);
        wb(1'b1, 5'h01, OFF_COMMAND, 4'h1, 32'h6);
        @(negedge clk_i);
        chk(flags, 5'h1F);
        chk(discard, 1'b1);
        $display("test grouping and chain end done");
        wb(1'b0, 5'h01, OFF_LINK_CFG0, 4'hF, 32'h0);
        chk(rd[7:0], {1'b0, MAX_W_OUT, 1'b0, MAX_W_IN});
        wb(1'b1, 5'h01, OFF_LINK_CFG0, 4'h2, {16'h0, 1'b0, WID_32, 1'b0,
            WID_16, 8'h00});
        @(negedge clk_i);
        chk(w_in[2:0], WID_8);
        chain_host_model_i.reconnect();
        @(negedge clk_i);
        chk(w_in, {WID_8, WID_16});
        chk(w_out, {WID_8, WID_32});
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk(w_in, {WID_8, WID_16});
        chk(w_out, {WID_8, WID_32});
        chk(base, 5'h00);
        chk({flags, discard}, 6'h00);
        $display("test link widths done");
        print_verdict();
    end
endmodule
`default_nettype wire

/* hw/io_chain_cfg.sv */
// configuration logic of one chain device behind a wishbone slave
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module io_chain_cfg
    import io_chain_pkg::*;
#(
    parameter logic [TAG_W-1:0] TAG_SLOT_COUNT = 5'h01,
    parameter logic [WID_W-1:0] MAX_IN_WIDTH = 3'h3,
    parameter logic [WID_W-1:0] MAX_OUT_WIDTH = 3'h3
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic link_src_i,
    input wire logic power_good_i,
    input wire logic link_stop_n_i,
    input wire logic [LINK_COUNT-1:0] init_done_i,
    input wire logic [LINK_COUNT-1:0] link_err_i,
    input wire logic [LINK_COUNT-1:0] neg_done_i,
    input wire logic [LINK_COUNT*WID_W-1:0] neg_in_i,
    input wire logic [LINK_COUNT*WID_W-1:0] neg_out_i,
    output logic power_good_sec_o,
    output logic reset_sec_o,
    output logic host_link_o,
    output logic default_dir_o,
    output logic bus_master_o,
    output logic [TAG_W-1:0] base_tag_number_o,
    output logic discard_dead_o,
    output logic chain_terminus_flag_o,
    output logic transmitter_shutdown_o,
    output logic tag_reorder_block_o,
    output logic [LINK_COUNT*WID_W-1:0] width_in_o,
    output logic [LINK_COUNT*WID_W-1:0] width_out_o
);
    // ---------------------------------------------------------------
    // address decode helpers
    // ---------------------------------------------------------------
    function automatic logic [TAG_W-1:0] dev_of(input logic [ADR_W-1:0] a);
        dev_of = a[ADR_W-1:DEV_LSB];
    endfunction

    function automatic logic [6:0] off_of(input logic [ADR_W-1:0] a);
        off_of = {a[DEV_LSB-1:2], 2'b00};
    endfunction

    function automatic logic [6:0] cfg_off(input int i);
        cfg_off = OFF_LINK_CFG0 + 7'(i) * OFF_LINK_STEP;
    endfunction

    logic ack_ff, nxt_ack;
    logic err_ff, nxt_err;
    logic [31:0] dat_ff, nxt_dat;
    logic host_link_ff, nxt_host_link;
    logic default_dir_ff, nxt_default_dir;
    logic bus_master_ff, nxt_bus_master;
    logic [TAG_W-1:0] base_tag_ff, nxt_base_tag;
    logic [3:0] ctrl_ff, nxt_ctrl;
    logic [LINK_COUNT-1:0] err_sticky_ff, nxt_err_sticky;
    logic pg_sec_ff, nxt_pg_sec;
    logic rst_sec_ff;
    logic req, hit, commit;
    logic [6:0] off;
    logic [31:0] rd_data;
    logic [LINK_COUNT-1:0] prog_wr;
    logic [LINK_COUNT*WID_W-1:0] prog_in, prog_out, act_in, act_out;

    // ---------------------------------------------------------------
    // width control per link
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LINK_COUNT; g++)
        begin : g_link
            link_width_ctl link_width_ctl_i (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .power_good_i(power_good_i),
                .link_stop_n_i(link_stop_n_i),
                .neg_done_i(neg_done_i[g]),
                .neg_in_i(neg_in_i[g*WID_W +: WID_W]),
                .neg_out_i(neg_out_i[g*WID_W +: WID_W]),
                .prog_wr_i(prog_wr[g]),
                .prog_in_i(wb_dat_i[CFG_PRG_IN +: WID_W]),
                .prog_out_i(wb_dat_i[CFG_PRG_OUT +: WID_W]),
                .prog_in_o(prog_in[g*WID_W +: WID_W]),
                .prog_out_o(prog_out[g*WID_W +: WID_W]),
                .act_in_o(act_in[g*WID_W +: WID_W]),
                .act_out_o(act_out[g*WID_W +: WID_W])
            );
            // programmed widths only take effect at warm reset or reconnect
            assign prog_wr[g] = commit && off == cfg_off(g) && wb_sel_i[1];
        end
    endgenerate

    // ---------------------------------------------------------------
    // request decode; only the holder of the addressed tag claims it
    // ---------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i;
    assign off = off_of(wb_adr_i);
    assign hit = dev_of(wb_adr_i) == base_tag_ff;
    // a write lands on the edge that sees the acknowledge
    assign commit = req && wb_we_i && ack_ff;

    // read multiplexer; unmapped offsets read as zero
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (off)
            OFF_COMMAND:
            begin
                rd_data[CMD_HOST_LINK] = host_link_ff;
                rd_data[CMD_DEFAULT_DIR] = default_dir_ff;
                rd_data[CMD_BUS_MASTER] = bus_master_ff;
            end
            OFF_BASE_TAG: rd_data[TAG_W-1:0] = base_tag_ff;
            OFF_LINK_CTRL: rd_data[3:0] = ctrl_ff;
            OFF_STATUS:
            begin
                rd_data[STS_INIT_LSB +: LINK_COUNT] = init_done_i;
                rd_data[STS_ERR_LSB +: LINK_COUNT] = err_sticky_ff;
            end
            OFF_SLOT_COUNT: rd_data[TAG_W-1:0] = TAG_SLOT_COUNT;
            default: rd_data = 32'h0000_0000;
        endcase
        for (int i = 0; i < LINK_COUNT; i++)
        begin
            if (off == cfg_off(i))
            begin
                rd_data[CFG_MAX_IN +: WID_W] = MAX_IN_WIDTH;
                rd_data[CFG_MAX_OUT +: WID_W] = MAX_OUT_WIDTH;
                rd_data[CFG_PRG_IN +: WID_W] = prog_in[i*WID_W +: WID_W];
                rd_data[CFG_PRG_OUT +: WID_W] = prog_out[i*WID_W +: WID_W];
                rd_data[CFG_ACT_IN +: WID_W] = act_in[i*WID_W +: WID_W];
                rd_data[CFG_ACT_OUT +: WID_W] = act_out[i*WID_W +: WID_W];
            end
        end
    end

    // ---------------------------------------------------------------
    // next values of the bus answer and the register file
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_ack = 1'b0;
        nxt_err = 1'b0;
        nxt_dat = dat_ff;
        nxt_host_link = host_link_ff;
        nxt_default_dir = default_dir_ff;
        nxt_bus_master = bus_master_ff;
        nxt_base_tag = base_tag_ff;
        nxt_ctrl = ctrl_ff;
        nxt_pg_sec = power_good_i;
        // answer one cycle after the request, for one cycle only
        if (req && !ack_ff && !err_ff)
        begin
            nxt_ack = hit;
            nxt_err = !hit;    // not ours: pass it down the chain
            nxt_dat = hit ? rd_data : 32'h0000_0000;
        end
        if (commit)
        begin
            case (off)
                OFF_COMMAND:
                begin
                    // even a write that keeps every field marks the link
                    nxt_host_link = link_src_i;
                    if (wb_sel_i[0])
                    begin
                        nxt_default_dir = wb_dat_i[CMD_DEFAULT_DIR];
                        nxt_bus_master = wb_dat_i[CMD_BUS_MASTER];
                    end
                end
                OFF_BASE_TAG:
                    if (wb_sel_i[0])
                        nxt_base_tag = wb_dat_i[TAG_W-1:0];
                OFF_LINK_CTRL:
                    if (wb_sel_i[0])
                        nxt_ctrl = wb_dat_i[3:0];
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        // error events stick; a new event beats a clear in the same cycle
        nxt_err_sticky = err_sticky_ff;
        if (commit && off == OFF_STATUS && wb_sel_i[0])
            nxt_err_sticky = err_sticky_ff
                & ~wb_dat_i[STS_ERR_LSB +: LINK_COUNT];
        nxt_err_sticky = nxt_err_sticky | link_err_i;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
            host_link_ff <= 1'b0;
            default_dir_ff <= 1'b0;
            bus_master_ff <= 1'b0;
            base_tag_ff <= BASE_TAG_RST;
            ctrl_ff <= CTRL_RST;
            err_sticky_ff <= '0;
            pg_sec_ff <= 1'b0;
            rst_sec_ff <= 1'b1;
        end
        else if (ce_i)
        begin
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
            dat_ff <= nxt_dat;
            host_link_ff <= nxt_host_link;
            default_dir_ff <= nxt_default_dir;
            bus_master_ff <= nxt_bus_master;
            base_tag_ff <= nxt_base_tag;
            ctrl_ff <= nxt_ctrl;
            err_sticky_ff <= nxt_err_sticky;
            pg_sec_ff <= nxt_pg_sec;
            rst_sec_ff <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // outputs; only secondary-side copies exist, nothing drives primary
    // ---------------------------------------------------------------
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = dat_ff;
    assign power_good_sec_o = pg_sec_ff;
    assign reset_sec_o = rst_sec_ff;
    assign host_link_o = host_link_ff;
    assign default_dir_o = default_dir_ff;
    assign bus_master_o = bus_master_ff;
    assign base_tag_number_o = base_tag_ff;
    assign discard_dead_o = ctrl_ff[CTL_DISCARD];
    assign chain_terminus_flag_o = ctrl_ff[CTL_TERMINUS];
    assign transmitter_shutdown_o = ctrl_ff[CTL_TX_OFF];
    assign tag_reorder_block_o = ctrl_ff[CTL_REORDER];
    assign width_in_o = act_in;
    assign width_out_o = act_out;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence zero_req_seq;
        ce_i && req && !ack_ff && !err_ff && dev_of(wb_adr_i) == 5'h00;
    endsequence

    chk_reset_tag_zero: assert property (@(posedge clk_i)
        rst_i ##1 !rst_i |-> base_tag_ff == 5'h00 && !ack_ff)
        else $error("device left reset away from tag zero");

    chk_zero_answered: assert property (@(posedge clk_i) disable iff (rst_i)
        zero_req_seq ##0 base_tag_ff == 5'h00 ##1 ce_i
        |-> wb_ack_o && !wb_err_o ##1 !wb_ack_o)
        else $error("tag zero access not answered by fresh device");

    chk_cmd_marks_link: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && commit && off == OFF_COMMAND
        |=> host_link_o == $past(link_src_i))
        else $error("command write did not mark the arrival link");

    chk_zero_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        zero_req_seq ##0 base_tag_ff != 5'h00 |=> wb_err_o && !wb_ack_o)
        else $error("programmed device still answered tag zero");

    chk_fwd_power: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> power_good_sec_o == $past(power_good_i))
        else $error("power-good not forwarded to the secondary side");

    chk_discard_idle: assert property (@(posedge clk_i)
        rst_i |=> !discard_dead_o [*1] ##0 !rst_sec_ff == !$past(rst_i))
        else $error("discard-on-dead-link active after reset");
endmodule
`default_nettype wire

/* hw/link_width_ctl.sv */
// per-link width fields: negotiated load, programmed value, applied value
`timescale 1ns/1ps
`default_nettype none
module link_width_ctl
    import io_chain_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic power_good_i,
    input wire logic link_stop_n_i,
    input wire logic neg_done_i,
    input wire logic [WID_W-1:0] neg_in_i,
    input wire logic [WID_W-1:0] neg_out_i,
    input wire logic prog_wr_i,
    input wire logic [WID_W-1:0] prog_in_i,
    input wire logic [WID_W-1:0] prog_out_i,
    output logic [WID_W-1:0] prog_in_o,
    output logic [WID_W-1:0] prog_out_o,
    output logic [WID_W-1:0] act_in_o,
    output logic [WID_W-1:0] act_out_o
);
    // ---------------------------------------------------------------
    // width ranking and clipping
    // ---------------------------------------------------------------
    function automatic logic [1:0] rank(input logic [WID_W-1:0] w);
        case (w)
            WID_2: rank = 2'h1;
            WID_4: rank = 2'h2;
            WID_OFF: rank = 2'h0;
            default: rank = 2'h3;    // 8 bits or wider
        endcase
    endfunction

    // hardware picks only a narrow symmetric width, never 16/32 or mixed
    function automatic logic [WID_W-1:0] clip(input logic [WID_W-1:0] a,
                                              input logic [WID_W-1:0] b);
        logic [WID_W-1:0] n;
        n = (rank(a) < rank(b)) ? a : b;
        clip = (rank(n) == 2'h3) ? WID_8 : n;
    endfunction

    logic cold_ff, nxt_cold;
    logic stop_prev_ff, nxt_stop_prev;
    logic [WID_W-1:0] pin_ff, nxt_pin, pout_ff, nxt_pout;
    logic [WID_W-1:0] ain_ff, nxt_ain, aout_ff, nxt_aout;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_cold = cold_ff;
        nxt_stop_prev = link_stop_n_i;
        nxt_pin = pin_ff;
        nxt_pout = pout_ff;
        nxt_ain = ain_ff;
        nxt_aout = aout_ff;
        if (!power_good_i)
        begin
            nxt_cold = 1'b1;
            nxt_pin = WID_8;
            nxt_pout = WID_8;
            nxt_ain = WID_8;
            nxt_aout = WID_8;
        end
        else if (cold_ff && neg_done_i)
        begin
            nxt_cold = 1'b0;
            nxt_pin = clip(neg_in_i, neg_out_i);
            nxt_pout = clip(neg_in_i, neg_out_i);
            nxt_ain = clip(neg_in_i, neg_out_i);
            nxt_aout = clip(neg_in_i, neg_out_i);
        end
        else
        begin
            if (prog_wr_i)
            begin
                nxt_pin = prog_in_i;
                nxt_pout = prog_out_i;
            end
            // reconnect applies the programmed widths like a warm reset
            if (!stop_prev_ff && link_stop_n_i)
            begin
                nxt_ain = pin_ff;
                nxt_aout = pout_ff;
            end
        end
    end

    // ---------------------------------------------------------------
    // registers; warm reset applies but never clears programmed widths
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i && power_good_i)
        begin
            stop_prev_ff <= 1'b1;
            ain_ff <= pin_ff;
            aout_ff <= pout_ff;
        end
        else if (rst_i || ce_i)
        begin
            cold_ff <= nxt_cold;
            stop_prev_ff <= nxt_stop_prev;
            pin_ff <= nxt_pin;
            pout_ff <= nxt_pout;
            ain_ff <= nxt_ain;
            aout_ff <= nxt_aout;
        end
    end

    assign prog_in_o = pin_ff;
    assign prog_out_o = pout_ff;
    assign act_in_o = ain_ff;
    assign act_out_o = aout_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence reconnect_seq;
        ce_i && !link_stop_n_i ##1 ce_i && link_stop_n_i;
    endsequence

    chk_no_wide_auto: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && power_good_i && cold_ff && neg_done_i |=>
        ain_ff != WID_16 && ain_ff != WID_32 && ain_ff == aout_ff)
        else $error("negotiation enabled a wide or mixed width");

    chk_warm_keep: assert property (@(posedge clk_i)
        rst_i && power_good_i |=> $stable(pin_ff) && ain_ff == $past(pin_ff))
        else $error("warm reset lost or failed to apply widths");

    chk_stop_apply: assert property (@(posedge clk_i) disable iff (rst_i)
        reconnect_seq ##0 power_good_i && !cold_ff && !prog_wr_i
        |=> ain_ff == $past(pin_ff) && aout_ff == $past(pout_ff))
        else $error("reconnect did not apply programmed widths");
endmodule
`default_nettype wire

/* inc/io_chain_pkg.sv */
// constants shared by the chain device configuration logic
`default_nettype none
package io_chain_pkg;
    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int ADR_W = 12;
    localparam int DEV_LSB = 7;     // address bits 11:7 pick a device tag
    localparam int TAG_W = 5;
    localparam int LINK_COUNT = 2;
    localparam int WID_W = 3;
    // ---------------------------------------------------------------
    // register byte offsets inside one device window
    // ---------------------------------------------------------------
    localparam logic [6:0] OFF_COMMAND = 7'h00;
    localparam logic [6:0] OFF_BASE_TAG = 7'h04;
    localparam logic [6:0] OFF_LINK_CTRL = 7'h08;
    localparam logic [6:0] OFF_STATUS = 7'h0C;
    localparam logic [6:0] OFF_LINK_CFG0 = 7'h10;
    localparam logic [6:0] OFF_LINK_STEP = 7'h04;
    localparam logic [6:0] OFF_SLOT_COUNT = 7'h18;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CMD_HOST_LINK = 0;
    localparam int CMD_DEFAULT_DIR = 1;
    localparam int CMD_BUS_MASTER = 2;
    localparam int CTL_DISCARD = 0;
    localparam int CTL_TERMINUS = 1;
    localparam int CTL_TX_OFF = 2;
    localparam int CTL_REORDER = 3;
    localparam int STS_INIT_LSB = 0;
    localparam int STS_ERR_LSB = 4;
    localparam int CFG_MAX_IN = 0;
    localparam int CFG_MAX_OUT = 4;
    localparam int CFG_PRG_IN = 8;
    localparam int CFG_PRG_OUT = 12;
    localparam int CFG_ACT_IN = 16;
    localparam int CFG_ACT_OUT = 20;
    // ---------------------------------------------------------------
    // reset values and width codes
    // ---------------------------------------------------------------
    localparam logic [TAG_W-1:0] BASE_TAG_RST = 5'h00;
    localparam logic [3:0] CTRL_RST = 4'h0;   // discard starts inactive
    localparam logic [WID_W-1:0] WID_8 = 3'h0;
    localparam logic [WID_W-1:0] WID_16 = 3'h1;
    localparam logic [WID_W-1:0] WID_32 = 3'h3;
    localparam logic [WID_W-1:0] WID_2 = 3'h4;
    localparam logic [WID_W-1:0] WID_4 = 3'h5;
    localparam logic [WID_W-1:0] WID_OFF = 3'h7;
endpackage
`default_nettype wire
